/* File: dv/stcal_chk.sv */
// stcal_chk: port-level checks for stcal_top.
// assumes one clock and a sync reset; bound to every stcal_top.
`default_nettype none
module stcal_chk (
	input wire logic clk, // clock
	input wire logic reset, // sync reset
	input wire logic hsel, // ahb select
	input wire logic [7:0] haddr, // ahb address
	input wire logic [1:0] htrans, // ahb transfer
	input wire logic hwrite, // ahb write
	input wire logic [31:0] hwdata, // ahb write data
	input wire logic hready, // ahb ready in
	input wire logic [31:0] hrdata, // ahb read data
	input wire logic hreadyout, // ahb ready out
	input wire logic hresp, // ahb response
	input wire logic discharge, // discharge phase
	input wire logic [1:0] switch_sel, // gage switch
	input wire logic sensor_resistor_port, // sensor path
	input wire logic reference_resistor_port, // reference path
	input wire logic calibrate // calibration active
);
	logic wr_q, rd_q, sens_seen;
	logic [7:0] a_q;
	logic [3:0] del;
	logic [4:0] cnt, prev_key;
	wire logic take = hsel && htrans[1] && hready;
	wire logic [4:0] key = {discharge, switch_sel, sensor_resistor_port,
		reference_resistor_port};
	// setting 0 behaves as 1
	wire logic [4:0] del_cyc = (del == 4'h0 ? 5'h01 : {1'b0, del}) + 5'h03;
	// cnt is the number of edges since the current phase was entered
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			del <= 4'h4;
			cnt <= 5'h00;
			prev_key <= 5'h00;
			sens_seen <= 1'b0;
			a_q <= 8'h00;
		end
		else
		begin
			wr_q <= take && hwrite;
			rd_q <= take && !hwrite;
			if (take)
				a_q <= haddr;
			if (wr_q && a_q == stcal_pkg::OFF_CFG1)
				del <= hwdata[3:0];
			prev_key <= key;
			if (discharge && key != prev_key)
				cnt <= 5'h01;
			else if (cnt != 5'h1f)
				cnt <= cnt + 5'h01;
			if (reference_resistor_port)
				sens_seen <= 1'b0;
			else if (sensor_resistor_port)
				sens_seen <= 1'b1;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	sequence cal_burst;
		calibrate [*4] ##1 !calibrate;
	endsequence
	a_ready_okay: assert property (hreadyout && !hresp)
		else $error("bus not ready or not okay");
	a_cal_length: assert property ($rose(calibrate) |-> cal_burst)
		else $error("calibration length wrong");
	a_cal_in_dis: assert property (calibrate |-> discharge)
		else $error("calibration outside discharge");
	a_cal_delay: assert property ($rose(calibrate) |-> cnt == del_cyc)
		else $error("calibration start misplaced");
	a_temp_excl: assert property (!(sensor_resistor_port &&
		reference_resistor_port))
		else $error("both temperature paths on");
	a_temp_order: assert property ($rose(reference_resistor_port) |->
		sens_seen)
		else $error("reference before sensor");
	a_gage_switch: assert property (discharge && !sensor_resistor_port &&
		!reference_resistor_port |-> switch_sel != 2'h0)
		else $error("gage discharge without switch");
	a_unmapped_zero: assert property (rd_q && a_q >= 8'h38 |-> hrdata == 32'h0)
		else $error("unmapped read not zero");
endmodule
bind stcal_top stcal_chk u_chk (.clk(clk), .reset(reset), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.discharge(discharge), .switch_sel(switch_sel),
	.sensor_resistor_port(sensor_resistor_port),
	.reference_resistor_port(reference_resistor_port),
	.calibrate(calibrate));
`default_nettype wire

/* File: dv/stcal_res_model.sv */
// stcal_res_model: external resistors and capacitor as seen by the converter.
// assumes discharge and path selects are held for a whole phase.
`default_nettype none
module stcal_res_model (
	input wire logic clk, // clock
	input wire logic discharge, // discharge active
	input wire logic [1:0] switch_sel, // gage switch
	input wire logic sensor_resistor_port, // sensor path
	input wire logic reference_resistor_port, // reference path
	input wire logic [23:0] dur_gage, // gage discharge cycles
	input wire logic [23:0] dur_sens, // sensor discharge cycles
	input wire logic [23:0] dur_ref, // reference discharge cycles
	output logic interval_valid, // interval pulse
	output logic [23:0] interval // measured cycles
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] prev_key = 5'h00;
	logic [23:0] cnt = 24'h0;
	wire logic [4:0] key = {discharge, switch_sel, sensor_resistor_port,
		reference_resistor_port};
	wire logic [23:0] dur = sensor_resistor_port ? dur_sens :
		(reference_resistor_port ? dur_ref : dur_gage);
	wire logic fire = discharge && key == prev_key && cnt + 24'h1 == dur;
	initial
	begin
		interval_valid = 1'b0;
		interval = 24'h0;
	end
	// outside the pulse the result lines toggle so stale data never looks valid
	always @(posedge clk)
	begin
		prev_key <= key;
		cnt <= (discharge && key != prev_key) ? 24'h1 : cnt + 24'h1;
		interval_valid <= fire;
		interval <= fire ? dur : ~interval;
	end
endmodule
`default_nettype wire

/* File: dv/strain_tdc_calib_temp_control_tb.sv */
// strain_tdc_calib_temp_control_tb: register table, measurement runs,
// temperature rates and abort. assumes zero-wait ahb slave.
`default_nettype none
module strain_tdc_calib_temp_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic wr; logic [7:0] a; logic [31:0] d, e;} stcal_row_s;
	logic clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, sp = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0, rd;
	logic [23:0] dur_g = 24'h46, dur_s = 24'h64, dur_r = 24'h50;
	wire logic [31:0] hrdata;
	wire logic [23:0] interval;
	wire logic [1:0] switch_sel;
	wire logic hreadyout, hresp, irq, ivalid, discharge, sens, refr, calibrate;
	int miscompares = 0, num_checks = 0, sens_runs = 0;
	int runs[4] = '{6, 6, 6, 9};
	int temps[4] = '{0, 6, 1, 1};
	stcal_row_s rows[8] = '{
		'{1'b0, stcal_pkg::OFF_CFG0, 32'h0, stcal_pkg::RST_CFG0},
		'{1'b0, stcal_pkg::OFF_CFG2, 32'h0, stcal_pkg::RST_CFG2},
		'{1'b0, stcal_pkg::OFF_CFG1, 32'h0, stcal_pkg::RST_CFG1},
		'{1'b1, stcal_pkg::OFF_CFG1, 32'h5, 32'h0},
		'{1'b0, stcal_pkg::OFF_CFG1, 32'h0, 32'h5},
		'{1'b1, 8'h38, 32'hffff_ffff, 32'h0},
		'{1'b0, 8'h38, 32'h0, 32'h0},
		'{1'b1, stcal_pkg::OFF_MASK, 32'h7, 32'h0}};
	always #12.5 clk = ~clk;
	always @(posedge clk)
	begin
		sp <= sens;
		if (sens && !sp)
			sens_runs++;
	end
	stcal_top DUT (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .irq(irq), .interval_valid(ivalid),
		.interval(interval), .discharge(discharge), .switch_sel(switch_sel),
		.sensor_resistor_port(sens), .reference_resistor_port(refr),
		.calibrate(calibrate));
	stcal_res_model u_res (.clk(clk), .discharge(discharge),
		.switch_sel(switch_sel), .sensor_resistor_port(sens),
		.reference_resistor_port(refr), .dur_gage(dur_g), .dur_sens(dur_s),
		.dur_ref(dur_r), .interval_valid(ivalid), .interval(interval));
	task wrap_up;
		if (miscompares == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task edge_rdy;
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			miscompares++;
			wrap_up;
		end
	endtask
	task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		edge_rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		edge_rdy;
		rd = hrdata;
	endtask
	// polls status, so a hung sequence ends in the report instead of a hang
	task run;
		int n;
		n = 0;
		xfer(1'b1, stcal_pkg::OFF_STAT, 32'h7);
		xfer(1'b1, stcal_pkg::OFF_CMD, 32'h1);
		do
		begin
			xfer(1'b0, stcal_pkg::OFF_STAT, 32'h0);
			n++;
		end
		while (rd[stcal_pkg::ST_DONE] !== 1'b1 && n < 400);
		if (n >= 400)
		begin
			miscompares++;
			wrap_up;
		end
	endtask
	initial
	begin
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		foreach (rows[i])
		begin
			xfer(rows[i].wr, rows[i].a, rows[i].d);
			if (!rows[i].wr)
				chk(rd, rows[i].e);
		end
		xfer(1'b1, stcal_pkg::OFF_CFG2, 32'h0004_0100);
		run;
		chk(rd & 32'h7, 32'h5);
		chk({31'h0, irq}, 32'h1);
		xfer(1'b0, stcal_pkg::OFF_TEMP, 32'h0);
		chk(rd & 32'hffff, 32'h5000);
		xfer(1'b1, stcal_pkg::OFF_STAT, 32'h7);
		xfer(1'b0, stcal_pkg::OFF_STAT, 32'h0);
		chk({rd[31:1], irq}, 32'h0);
		// temperature off and a gage interval below the minimum
		xfer(1'b1, stcal_pkg::OFF_CFG2, 32'h0004_0000);
		dur_s <= 24'h78;
		dur_g <= 24'h28;
		run;
		chk(rd & 32'h7, 32'h3);
		xfer(1'b0, stcal_pkg::OFF_TEMP, 32'h0);
		chk(rd & 32'hffff, 32'h5000);
		dur_g <= 24'h46;
		for (int c = 0; c < 4; c++)
		begin
			xfer(1'b1, stcal_pkg::OFF_CMD, 32'h2);
			xfer(1'b1, stcal_pkg::OFF_CFG2, 32'h0004_0000 | (c << 8));
			sens_runs = 0;
			repeat (runs[c]) run;
			chk(sens_runs, temps[c]);
		end
		xfer(1'b1, stcal_pkg::OFF_STAT, 32'h7);
		xfer(1'b1, stcal_pkg::OFF_CMD, 32'h1);
		repeat (20) @(posedge clk);
		xfer(1'b1, stcal_pkg::OFF_CMD, 32'h2);
		@(posedge clk);
		chk({31'h0, discharge}, 32'h0);
		xfer(1'b0, stcal_pkg::OFF_STAT, 32'h0);
		chk({rd[31:1], irq}, 32'h0);
		xfer(1'b0, stcal_pkg::OFF_CORR1, 32'h0);
		chk(rd, 32'h0);
		xfer(1'b0, stcal_pkg::OFF_CFG1, 32'h0);
		chk(rd, 32'h5);
		wrap_up;
	end
endmodule
`default_nettype wire

/* File: verilog/stcal_avg.sv */
// stcal_avg: running average y += (x - y) >> shift.
// assumes signed 24-bit samples, shift chosen by the caller.
`default_nettype none
module stcal_avg (
	input wire logic clk, // clock
	input wire logic reset, // sync reset, also clear
	input wire logic load, // take seed value
	input wire logic [23:0] seed, // seed value
	input wire logic sample_valid, // new sample
	input wire logic [23:0] sample, // sample
	input wire logic [4:0] shift, // log2 of averaging factor
	output logic [23:0] avg // averaged value
);
	wire logic signed [24:0] diff;
	wire logic signed [24:0] step;
	assign diff = $signed({sample[23], sample}) - $signed({avg[23], avg});
	assign step = diff >>> shift;
	always_ff @(posedge clk)
	begin
		if (reset)
			avg <= 24'h000000;
		else if (load)
			avg <= seed;
		else if (sample_valid)
			avg <= avg + step[23:0];
	end
endmodule
`default_nettype wire

/* File: verilog/stcal_pkg.sv */
// stcal_pkg: register map, field layout, reset values and timing counts for
// the calibration, switch-resistance and temperature control block.
// assumes a single 40 MHz clock and an AHB-Lite register port.
`default_nettype none
package stcal_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CFG0 = 8'h00;
	localparam logic [7:0] OFF_CFG2 = 8'h08;
	localparam logic [7:0] OFF_TEMP = 8'h0c;
	localparam logic [7:0] OFF_CORR1 = 8'h18;
	localparam logic [7:0] OFF_CORR2 = 8'h1c;
	localparam logic [7:0] OFF_SEED1 = 8'h20;
	localparam logic [7:0] OFF_SEED2 = 8'h24;
	localparam logic [7:0] OFF_CMD = 8'h28;
	localparam logic [7:0] OFF_STAT = 8'h2c;
	localparam logic [7:0] OFF_MASK = 8'h30;
	localparam logic [7:0] OFF_CFG1 = 8'h34;
	// cfg0 fields
	localparam int CAL_AVG_LSB = 22;
	localparam int SIMPLE_BIT = 21;
	// cfg2 fields
	localparam int CAL_INT_LSB = 0;
	localparam int TEMP_RATE_LSB = 8;
	localparam int SW_AVG_LSB = 12;
	localparam int ADAPT_LSB = 16;
	// cfg1 fields
	localparam int CAL_DEL_LSB = 0;
	// reset values
	localparam logic [31:0] RST_CFG0 = 32'h0080_0000;
	localparam logic [31:0] RST_CFG2 = 32'h0004_0102;
	localparam logic [31:0] RST_CFG1 = 32'h0000_0004;
	// command bits
	localparam int CMD_START = 0;
	localparam int CMD_REINIT = 1;
	// status bits
	localparam int ST_DONE = 0;
	localparam int ST_TIMEOUT = 1;
	localparam int ST_TEMP = 2;
	// timing
	localparam int CLK_MHZ = 40;
	localparam int MIN_INTERVAL_NS = 1500;
	localparam int MIN_INTERVAL_CYC = (MIN_INTERVAL_NS * CLK_MHZ + 999) / 1000;
	localparam logic [4:0] CAL_DEL_EXTRA = 5'h03;
	localparam logic [2:0] CAL_CYCLES = 3'h4;
	localparam logic [3:0] TEMP_EVERY6 = 4'h6;
	localparam logic [3:0] TEMP_EVERY9 = 4'h9;
	typedef enum logic [2:0] {
		ST_IDLE, ST_DIS_A, ST_DIS_B, ST_DIS_AB, ST_TEMP_S, ST_TEMP_R, ST_END
	} stcal_phase_e;
endpackage
`default_nettype wire

/* File: verilog/stcal_top.sv */
// stcal_top: calibration placement, switch-resistance compensation and
// ratiometric temperature control, with an AHB-Lite register port.
// assumes discharge intervals arrive as cycle counts from the converter.
// What this block does
// - calibration starts calibration_delay plus three fast periods after discharge.
// - each calibration measurement lasts four clock cycles.
// - calibration_interval sets measurement cycles between calibrations (15 acts as 14), 0 means every cycle.
// - calibration_average bits 23:22 of register 0 choose off, 8, 32, 64.
// - three discharges per gage: first switch, second switch, both parallel.
// - switch_resistance_average selects averaging factor two to the field.
// - switch_resistance_adapt_speed speeds convergence after reinitialize.
// - corrections readable at registers 6 and 7; stored values seed them.
// - simplified_switch_compensation bit 21 uses reduced-effort correction.
// - temperature takes sensor then reference discharge, once per sequence.
// - ratio sensor over reference placed unsigned 2.14 in read register 3.
// - discharge shorter than minimum measurable interval flags a timeout.
// - temperature_rate 0 off, 1 every, 2 every sixth, 3 every ninth.
// - reinitialize stops measurement, suppresses only the done flag, reloads corrections from the stored seeds.
`default_nettype none
module stcal_top (
	input wire logic clk, // 40 MHz clock
	input wire logic reset, // sync reset, active high
	input wire logic hsel, // ahb select
	input wire logic [7:0] haddr, // ahb address
	input wire logic [1:0] htrans, // ahb transfer type
	input wire logic hwrite, // ahb write
	input wire logic [2:0] hsize, // ahb size
	input wire logic [31:0] hwdata, // ahb write data
	input wire logic hready, // ahb ready in
	output logic [31:0] hrdata, // ahb read data
	output logic hreadyout, // ahb ready out
	output logic hresp, // ahb response, always okay
	output logic irq, // level interrupt
	input wire logic interval_valid, // converter interval ready
	input wire logic [23:0] interval, // discharge time in cycles
	output logic discharge, // discharge phase active
	output logic [1:0] switch_sel, // switch 1, 2 or both
	output logic sensor_resistor_port, // discharge via sensor
	output logic reference_resistor_port, // discharge via reference
	output logic calibrate // calibration in progress
);
	logic [31:0] cfg0;
	logic [31:0] cfg1;
	logic [31:0] cfg2;
	logic [23:0] seed1;
	logic [23:0] seed2;
	logic [2:0] status;
	logic [2:0] mask;
	logic [15:0] temp_result;
	logic [23:0] res_a;
	logic [23:0] res_b;
	logic [23:0] sens_t;
	logic [23:0] ref_t;
	logic [15:0] quot;
	logic [4:0] del_cnt;
	logic [2:0] cal_cnt;
	logic cal_done_phase;
	logic [3:0] cal_seq;
	logic [3:0] temp_seq;
	logic [3:0] adapt_left;
	logic seeded;
	logic temp_done_pending;
	logic ap_valid;
	logic ap_write;
	logic [7:0] ap_addr;
	stcal_pkg::stcal_phase_e phase;
	stcal_pkg::stcal_phase_e next_phase;

	wire logic [23:0] corr1;
	wire logic [23:0] corr2;
	wire logic [1:0] cal_avg;
	wire logic [3:0] cal_del;
	wire logic [3:0] cal_int;
	wire logic [1:0] temp_rate;
	wire logic [3:0] sw_avg;
	wire logic [3:0] adapt;
	wire logic simple;
	wire logic start_cmd;
	wire logic reinit_cmd;
	wire logic wr_cmd;
	wire logic too_short;
	wire logic seq_end;
	wire logic temp_due;
	wire logic cal_due;
	wire logic [4:0] del_target;
	wire logic [4:0] avg_shift;
	wire logic [23:0] sample1;
	wire logic [23:0] sample2;
	wire logic [3:0] next_temp_seq;
	wire logic [3:0] next_cal_seq;
	wire logic [39:0] ratio_full;

	function automatic logic is_addr(input logic [7:0] a, input logic [7:0] o);
		is_addr = (a == o);
	endfunction

	assign cal_avg = cfg0[stcal_pkg::CAL_AVG_LSB +: 2];
	assign simple = cfg0[stcal_pkg::SIMPLE_BIT];
	assign cal_del = cfg1[stcal_pkg::CAL_DEL_LSB +: 4];
	assign cal_int = cfg2[stcal_pkg::CAL_INT_LSB +: 4];
	assign temp_rate = cfg2[stcal_pkg::TEMP_RATE_LSB +: 2];
	assign sw_avg = cfg2[stcal_pkg::SW_AVG_LSB +: 4];
	assign adapt = cfg2[stcal_pkg::ADAPT_LSB +: 4];

	// ahb data phase
	assign wr_cmd = ap_valid && ap_write && is_addr(ap_addr, stcal_pkg::OFF_CMD);
	assign start_cmd = wr_cmd && hwdata[stcal_pkg::CMD_START];
	assign reinit_cmd = wr_cmd && hwdata[stcal_pkg::CMD_REINIT];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign irq = |(status & mask);

	// 1.5 us floor, in cycles
	assign too_short = interval_valid &&
		(interval < 24'(stcal_pkg::MIN_INTERVAL_CYC));
	assign seq_end = (phase == stcal_pkg::ST_END);
	// setting 0 is illegal; treat as 1 so the delay never shrinks below 4
	assign del_target = (cal_del == 4'h0) ? 5'h04 :
		({1'b0, cal_del} + stcal_pkg::CAL_DEL_EXTRA);
	assign cal_due = (cal_seq == 4'h0);
	assign next_cal_seq = (cal_seq == 4'h0) ?
		((cal_int == 4'h0) ? 4'h0 : (cal_int == 4'hf ? 4'he : cal_int))
		: cal_seq - 4'h1;
	assign temp_due = (temp_rate == 2'h1) ||
		((temp_rate != 2'h0) && (temp_seq == 4'h0));
	assign next_temp_seq = (temp_seq == 4'h0) ?
		((temp_rate == 2'h2) ? stcal_pkg::TEMP_EVERY6 - 4'h1 :
		stcal_pkg::TEMP_EVERY9 - 4'h1) : temp_seq - 4'h1;

	// adapt speed shortens the averaging right after reinit
	assign avg_shift = (adapt_left != 4'h0 && sw_avg > adapt) ?
		{1'b0, adapt} : {1'b0, sw_avg};
	// full mode: each switch's share; simplified: half of single-switch time
	assign sample1 = simple ? (res_a >> 1) : res_a - (interval >> 1);
	assign sample2 = simple ? (res_a >> 1) : res_b - (interval >> 1);

	stcal_avg u_avg1 (
		.clk(clk),
		.reset(reset || reinit_cmd),
		.load(!seeded),
		.seed(seed1),
		.sample_valid(interval_valid && phase == stcal_pkg::ST_DIS_AB),
		.sample(sample1),
		.shift(avg_shift),
		.avg(corr1)
	);
	stcal_avg u_avg2 (
		.clk(clk),
		.reset(reset || reinit_cmd),
		.load(!seeded),
		.seed(seed2),
		.sample_valid(interval_valid && phase == stcal_pkg::ST_DIS_AB),
		.sample(sample2),
		.shift(avg_shift),
		.avg(corr2)
	);

	// ratio in 2.14 format, saturating at the top
	assign ratio_full = ref_t == 24'h000000 ? 40'hff_ffff_ffff :
		({sens_t, 16'h0000} >> 2) / {16'h0000, ref_t};
	assign quot = (|ratio_full[39:16]) ? 16'hffff : ratio_full[15:0];

	always_comb
	begin
		next_phase = phase;
		case (phase)
			stcal_pkg::ST_IDLE:
				if (start_cmd)
					next_phase = stcal_pkg::ST_DIS_A;
			stcal_pkg::ST_DIS_A:
				if (interval_valid)
					next_phase = stcal_pkg::ST_DIS_B;
			stcal_pkg::ST_DIS_B:
				if (interval_valid)
					next_phase = stcal_pkg::ST_DIS_AB;
			stcal_pkg::ST_DIS_AB:
				if (interval_valid)
					next_phase = temp_due ? stcal_pkg::ST_TEMP_S :
						stcal_pkg::ST_END;
			stcal_pkg::ST_TEMP_S:
				if (interval_valid)
					next_phase = stcal_pkg::ST_TEMP_R;
			stcal_pkg::ST_TEMP_R:
				if (interval_valid)
					next_phase = stcal_pkg::ST_END;
			default:
				next_phase = stcal_pkg::ST_IDLE;
		endcase
		if (reinit_cmd)
			next_phase = stcal_pkg::ST_IDLE;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			phase <= stcal_pkg::ST_IDLE;
		else
			phase <= next_phase;
	end

	assign discharge = (phase != stcal_pkg::ST_IDLE) &&
		(phase != stcal_pkg::ST_END);
	assign switch_sel = (phase == stcal_pkg::ST_DIS_A) ? 2'h1 :
		(phase == stcal_pkg::ST_DIS_B) ? 2'h2 :
		(phase == stcal_pkg::ST_DIS_AB) ? 2'h3 : 2'h0;
	assign sensor_resistor_port = (phase == stcal_pkg::ST_TEMP_S);
	assign reference_resistor_port = (phase == stcal_pkg::ST_TEMP_R);
	assign calibrate = (cal_cnt != 3'h0);

	// calibration placement within each discharge phase
	always_ff @(posedge clk)
	begin
		if (reset || reinit_cmd || phase != next_phase)
		begin
			del_cnt <= 5'h00;
			cal_cnt <= 3'h0;
			cal_done_phase <= 1'b0;
		end
		else if (cal_cnt != 3'h0)
			cal_cnt <= cal_cnt - 3'h1;
		else if (discharge && cal_due && !cal_done_phase)
		begin
			if (del_cnt == del_target - 5'h01)
			begin
				cal_cnt <= stcal_pkg::CAL_CYCLES;
				cal_done_phase <= 1'b1;
			end
			else
				del_cnt <= del_cnt + 5'h01;
		end
	end

	// per-sequence counters and captured intervals
	always_ff @(posedge clk)
	begin
		if (reset || reinit_cmd)
		begin
			cal_seq <= 4'h0;
			temp_seq <= 4'h0;
			res_a <= 24'h000000;
			res_b <= 24'h000000;
			sens_t <= 24'h000000;
			ref_t <= 24'h000000;
			seeded <= 1'b0;
			adapt_left <= 4'hf;
		end
		else
		begin
			seeded <= 1'b1;
			if (interval_valid && phase == stcal_pkg::ST_DIS_A)
				res_a <= interval;
			if (interval_valid && phase == stcal_pkg::ST_DIS_B)
				res_b <= interval;
			if (interval_valid && phase == stcal_pkg::ST_TEMP_S)
				sens_t <= interval;
			if (interval_valid && phase == stcal_pkg::ST_TEMP_R)
				ref_t <= interval;
			if (seq_end)
			begin
				cal_seq <= next_cal_seq;
				if (temp_rate != 2'h0)
					temp_seq <= next_temp_seq;
				if (adapt_left != 4'h0)
					adapt_left <= adapt_left - 4'h1;
			end
		end
	end

	// temperature result holds across sequences without a measurement
	always_ff @(posedge clk)
	begin
		if (reset)
			temp_result <= 16'h0000;
		else if (seq_end && phase == stcal_pkg::ST_END && ref_t != 24'h0 &&
			sens_t != 24'h0 && temp_done_pending)
			temp_result <= quot;
	end

	always_ff @(posedge clk)
	begin
		if (reset || reinit_cmd)
			temp_done_pending <= 1'b0;
		else if (interval_valid && phase == stcal_pkg::ST_TEMP_R)
			temp_done_pending <= 1'b1;
		else if (seq_end)
			temp_done_pending <= 1'b0;
	end

	// ahb address phase capture
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ap_valid <= 1'b0;
			ap_write <= 1'b0;
			ap_addr <= 8'h00;
		end
		else if (hready)
		begin
			ap_valid <= hsel && htrans[1];
			ap_write <= hwrite;
			ap_addr <= haddr;
		end
	end

	// register writes
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			cfg0 <= stcal_pkg::RST_CFG0;
			cfg1 <= stcal_pkg::RST_CFG1;
			cfg2 <= stcal_pkg::RST_CFG2;
			seed1 <= 24'h000000;
			seed2 <= 24'h000000;
			mask <= 3'h0;
		end
		else if (ap_valid && ap_write)
		begin
			if (is_addr(ap_addr, stcal_pkg::OFF_CFG0))
				cfg0 <= hwdata;
			else if (is_addr(ap_addr, stcal_pkg::OFF_CFG1))
				cfg1 <= hwdata;
			else if (is_addr(ap_addr, stcal_pkg::OFF_CFG2))
				cfg2 <= hwdata;
			else if (is_addr(ap_addr, stcal_pkg::OFF_SEED1))
				seed1 <= hwdata[23:0];
			else if (is_addr(ap_addr, stcal_pkg::OFF_SEED2))
				seed2 <= hwdata[23:0];
			else if (is_addr(ap_addr, stcal_pkg::OFF_MASK))
				mask <= hwdata[2:0];
		end
	end

	// sticky status; a new event wins over a write-one clear
	wire logic [2:0] ev;
	wire logic [2:0] clr;
	assign ev[stcal_pkg::ST_DONE] = seq_end && !reinit_cmd;
	assign ev[stcal_pkg::ST_TIMEOUT] = too_short && discharge;
	assign ev[stcal_pkg::ST_TEMP] = seq_end && temp_done_pending;
	assign clr = (ap_valid && ap_write &&
		is_addr(ap_addr, stcal_pkg::OFF_STAT)) ? hwdata[2:0] : 3'h0;
	always_ff @(posedge clk)
	begin
		if (reset)
			status <= 3'h0;
		else
			status <= (status & ~clr) | ev;
	end

	// read mux
	wire logic [31:0] rd_mux;
	assign rd_mux =
		is_addr(ap_addr, stcal_pkg::OFF_CFG0) ? cfg0 :
		is_addr(ap_addr, stcal_pkg::OFF_CFG1) ? cfg1 :
		is_addr(ap_addr, stcal_pkg::OFF_CFG2) ? cfg2 :
		is_addr(ap_addr, stcal_pkg::OFF_TEMP) ? {16'h0000, temp_result} :
		is_addr(ap_addr, stcal_pkg::OFF_CORR1) ? {8'h00, corr1} :
		is_addr(ap_addr, stcal_pkg::OFF_CORR2) ? {8'h00, corr2} :
		is_addr(ap_addr, stcal_pkg::OFF_SEED1) ? {8'h00, seed1} :
		is_addr(ap_addr, stcal_pkg::OFF_SEED2) ? {8'h00, seed2} :
		is_addr(ap_addr, stcal_pkg::OFF_STAT) ? {29'h0, status} :
		is_addr(ap_addr, stcal_pkg::OFF_MASK) ? {29'h0, mask} : 32'h0;
	assign hrdata = rd_mux;
	// calibration averaging setting is held for the converter's own unit
	wire logic unused_cal_avg;
	assign unused_cal_avg = ^{cal_avg, hsize};
endmodule
`default_nettype wire
